//--- rtl/pimc_cfg.svh
// constants for the parallel input and mode control block
`ifndef PIMC_CFG_SVH
`define PIMC_CFG_SVH
`define PIMC_CHANNELS       8
`define PIMC_ADDR_W         8
`define PIMC_OFS_DIRECT     8'h00
`define PIMC_OFS_MAP_A      8'h04
`define PIMC_OFS_MAP_B      8'h08
`define PIMC_OFS_CONFIG     8'h0C
`define PIMC_OFS_PGEN_MAP   8'h10
`define PIMC_OFS_STATUS     8'h14
`define PIMC_RST_DIRECT     8'h00
`define PIMC_RST_MAP_A      8'h04
`define PIMC_RST_MAP_B      8'h08
`define PIMC_RST_PGEN_MAP   16'h0000
`define PIMC_BIT_KILL_UNMSK 0
`define PIMC_BIT_RST_UNMSK  1
`define PIMC_ST_IN_A        0
`define PIMC_ST_IN_B        1
`define PIMC_ST_KILL        2
`define PIMC_ST_RSTPIN      3
`define PIMC_ST_MODE_LO     4
`define PIMC_ST_MODE_HI     5
`define PIMC_RESP_OKAY      2'h0
`define PIMC_RESP_SLVERR    2'h2
`define PIMC_MODE_ACTIVE    2'h0
`define PIMC_MODE_FALLBACK  2'h1
`define PIMC_MODE_SLEEP     2'h2
`define PIMC_CLK_MHZ        20
`define PIMC_LP_FILT_NS     10000
`define PIMC_LP_FILT_CYC    ((`PIMC_LP_FILT_NS * `PIMC_CLK_MHZ) / 1000)
`endif

//--- rtl/pimc_pkg.sv
// types for the parallel input and mode control block
package pimc_pkg;
  typedef enum logic [1:0] {
    PIMC_ACTIVE,
    PIMC_FALLBACK,
    PIMC_SLEEP
  } pimc_mode_type;
endpackage : pimc_pkg

//--- rtl/pimc_filter.sv
// two-stage synchroniser followed by a stability filter
`timescale 1ns/10ps
module pimc_filter #(
  parameter int   CYC     = 1,
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // pin in, filtered level out
  input  wire logic pin_raw,
  output logic      level_q
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  logic          sync1_q;
  logic          sync2_q;
  logic [CW-1:0] cnt_q;
  wire           differs = sync2_q != level_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_q <= RST_VAL;
      sync2_q <= RST_VAL;
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // a level must hold for CYC samples before it is passed on
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q   <= '0;
      level_q <= RST_VAL;
    end
    else if (!differs)
      cnt_q <= '0;
    else if (cnt_q == LAST)
    begin
      cnt_q   <= '0;
      level_q <= sync2_q;
    end
    else
      cnt_q <= cnt_q + CW'(1);
  end
endmodule : pimc_filter

//--- rtl/pimc_top.sv
// parallel command inputs, operating mode and safety pin control
// Function
// RULE1: after reset input a drives channel 2, input b drives channel 3
// RULE2: each parallel input has a writable channel map register
// RULE3: channel command is OR of direct bit, mapped pulse generators, mapped inputs
// RULE4: input levels readable in status, also in fallback mode
// RULE5: lowpower low with an input high enters fallback, default channels driven
// RULE6: lowpower low and both inputs low enters sleep
// RULE7: controller holds each lowpower level at least the filter time
// RULE8: entering sleep returns all registers to defaults
// RULE9: undervoltage detectors are off in sleep
// RULE10: sleep refuses all bus transfers, serial output driver disabled
// RULE11: unmasked low reset pin holds internal reset, outputs off, registers default; the config unmask bits keep their value
// RULE12: reset pin ignored until its unmask bit is written
// RULE13: unmasked high kill pin switches all channels off
// RULE14: kill pin low leaves channels to their own commands
// RULE15: kill pin masked until its unmask bit is written
// RULE16: kill pin level readable in status
// RULE17: controller unmasks kill and reset pins through the config register
// RULE18: lowpower pin passes a digital filter before mode decisions
`timescale 1ns/10ps
`include "pimc_cfg.svh"
module pimc_top
  import pimc_pkg::*;
#(
  parameter int LP_FILT_CYC = `PIMC_LP_FILT_CYC,
  parameter int NCH         = `PIMC_CHANNELS
) (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    arst_n,
  // device pins
  input  wire logic                    parallel_cmd_input_a,
  input  wire logic                    parallel_cmd_input_b,
  input  wire logic                    lowpower_req_n,
  input  wire logic                    external_reset_n,
  input  wire logic                    output_kill_pin,
  // pulse generator outputs, same clock
  input  wire logic [1:0]              pgen_out,
  // channel drive and side controls
  output logic      [NCH-1:0]          channel_drive_q,
  output logic                         uv_detect_en_q,
  output logic                         serial_out_en_q,
  output logic                         internal_reset_q,
  output logic      [1:0]              mode_code_q,
  // axi4-lite write address
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [`PIMC_ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  // axi4-lite write response
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic      [1:0]              s_axi_bresp,
  // axi4-lite read address
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [`PIMC_ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic      [31:0]             s_axi_rdata,
  output logic      [1:0]              s_axi_rresp
);

  // synchronised and filtered pins
  logic in_a;
  logic in_b;
  logic lp_awake;
  logic rst_pin_n;
  logic kill_lvl;

  pimc_filter #(.CYC(1), .RST_VAL(1'b0)) u_flt_a (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .pin_raw (parallel_cmd_input_a),
    .level_q (in_a)
  );
  pimc_filter #(.CYC(1), .RST_VAL(1'b0)) u_flt_b (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .pin_raw (parallel_cmd_input_b),
    .level_q (in_b)
  );
  // a short glitch on the lowpower pin must not flip the mode
  pimc_filter #(.CYC(LP_FILT_CYC), .RST_VAL(1'b1)) u_flt_lp (  // see RULE18
    .mclk    (mclk),
    .arst_n  (arst_n),
    .pin_raw (lowpower_req_n),
    .level_q (lp_awake)
  );
  pimc_filter #(.CYC(1), .RST_VAL(1'b1)) u_flt_rst (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .pin_raw (external_reset_n),
    .level_q (rst_pin_n)
  );
  pimc_filter #(.CYC(1), .RST_VAL(1'b0)) u_flt_kill (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .pin_raw (output_kill_pin),
    .level_q (kill_lvl)
  );

  // registers
  logic [NCH-1:0]   direct_q;
  logic [NCH-1:0]   input_a_channel_map;
  logic [NCH-1:0]   input_b_channel_map;
  logic [2*NCH-1:0] pgen_map_q;
  logic             kill_pin_unmask;
  logic             reset_pin_unmask;
  pimc_mode_type    mode_q;
  pimc_mode_type    mode_d;

  // mode decision
  wire any_input = in_a | in_b;

  always_comb
  begin
    if (lp_awake)
      mode_d = PIMC_ACTIVE;
    else if (any_input)
      mode_d = PIMC_FALLBACK;  // see RULE5
    else
      mode_d = PIMC_SLEEP;  // see RULE6
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      mode_q <= PIMC_ACTIVE;
    else
      mode_q <= mode_d;
  end

  wire in_sleep    = mode_q == PIMC_SLEEP;
  wire in_fallback = mode_q == PIMC_FALLBACK;
  wire pin_reset   = reset_pin_unmask & ~rst_pin_n;  // see RULE11 RULE12
  wire kill_active = kill_pin_unmask & kill_lvl;  // see RULE13 RULE15
  // registers fall back to defaults in sleep and under the reset pin
  wire reg_clear   = in_sleep | pin_reset;  // see RULE8 RULE11

  // bus write path
  logic                    aw_got_q;
  logic                    w_got_q;
  logic [`PIMC_ADDR_W-1:0] waddr_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_got_q & w_got_q & ~s_axi_bvalid;

  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire        wr_direct = waddr_q == `PIMC_OFS_DIRECT;
  wire        wr_map_a  = waddr_q == `PIMC_OFS_MAP_A;
  wire        wr_map_b  = waddr_q == `PIMC_OFS_MAP_B;
  wire        wr_cfg    = waddr_q == `PIMC_OFS_CONFIG;
  wire        wr_pmap   = waddr_q == `PIMC_OFS_PGEN_MAP;
  wire        wr_stat   = waddr_q == `PIMC_OFS_STATUS;
  wire        wr_known  = wr_direct | wr_map_a | wr_map_b | wr_cfg | wr_pmap | wr_stat;
  // fallback keeps registers read-only, sleep refuses everything
  wire        wr_allow  = wr_known & ~wr_stat & ~in_sleep & ~in_fallback & ~pin_reset;  // see RULE10
  wire        wr_do     = wr_go & wr_allow;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  wire [31:0] direct_w = merge({24'h000000, direct_q}, wdata_q, wmask);
  wire [31:0] map_a_w  = merge({24'h000000, input_a_channel_map}, wdata_q, wmask);
  wire [31:0] map_b_w  = merge({24'h000000, input_b_channel_map}, wdata_q, wmask);
  wire [31:0] pmap_w   = merge({16'h0000, pgen_map_q}, wdata_q, wmask);
  wire [31:0] cfg_w    = merge({30'h00000000, reset_pin_unmask, kill_pin_unmask}, wdata_q, wmask);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      waddr_q  <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_got_q <= 1'b1;
        waddr_q  <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_got_q <= 1'b0;
      if (w_take)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (wr_go)
        w_got_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PIMC_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~(aw_got_q | aw_take);
      s_axi_wready  <= ~(w_got_q | w_take);
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_allow ? `PIMC_RESP_OKAY : `PIMC_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // software registers
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      direct_q            <= `PIMC_RST_DIRECT;
      input_a_channel_map <= `PIMC_RST_MAP_A;  // see RULE1
      input_b_channel_map <= `PIMC_RST_MAP_B;  // see RULE1
      pgen_map_q          <= `PIMC_RST_PGEN_MAP;
    end
    else if (reg_clear)
    begin
      direct_q            <= `PIMC_RST_DIRECT;
      input_a_channel_map <= `PIMC_RST_MAP_A;
      input_b_channel_map <= `PIMC_RST_MAP_B;
      pgen_map_q          <= `PIMC_RST_PGEN_MAP;
    end
    else if (wr_do)
    begin
      if (wr_direct)
        direct_q <= direct_w[NCH-1:0];
      if (wr_map_a)
        input_a_channel_map <= map_a_w[NCH-1:0];  // see RULE2
      if (wr_map_b)
        input_b_channel_map <= map_b_w[NCH-1:0];  // see RULE2
      if (wr_pmap)
        pgen_map_q <= pmap_w[2*NCH-1:0];
    end
  end

  // the unmask bits survive the reset pin, otherwise it could not hold the reset
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      kill_pin_unmask  <= 1'b0;  // see RULE15
      reset_pin_unmask <= 1'b0;  // see RULE12
    end
    else if (in_sleep)
    begin
      kill_pin_unmask  <= 1'b0;
      reset_pin_unmask <= 1'b0;
    end
    else if (wr_do & wr_cfg)
    begin
      kill_pin_unmask  <= cfg_w[`PIMC_BIT_KILL_UNMSK];  // see RULE17
      reset_pin_unmask <= cfg_w[`PIMC_BIT_RST_UNMSK];  // see RULE17
    end
  end

  // channel command
  wire [NCH-1:0] map_or  = ({NCH{in_a}} & input_a_channel_map) | ({NCH{in_b}} & input_b_channel_map);
  wire [NCH-1:0] pgen_or = ({NCH{pgen_out[0]}} & pgen_map_q[NCH-1:0])
                         | ({NCH{pgen_out[1]}} & pgen_map_q[2*NCH-1:NCH]);
  wire [NCH-1:0] cmd_act = direct_q | pgen_or | map_or;  // see RULE3
  wire [NCH-1:0] cmd_fb  = ({NCH{in_a}} & NCH'(`PIMC_RST_MAP_A))
                         | ({NCH{in_b}} & NCH'(`PIMC_RST_MAP_B));  // see RULE5
  wire [NCH-1:0] cmd_sel = in_fallback ? cmd_fb : (in_sleep ? '0 : cmd_act);
  // kill and reset pins override every command; with kill low the command passes
  wire [NCH-1:0] drive_d = (kill_active | pin_reset) ? '0 : cmd_sel;  // see RULE13 RULE14 RULE11

  wire [1:0] mode_code = in_sleep ? `PIMC_MODE_SLEEP : (in_fallback ? `PIMC_MODE_FALLBACK : `PIMC_MODE_ACTIVE);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      channel_drive_q  <= '0;
      uv_detect_en_q   <= 1'b1;
      serial_out_en_q  <= 1'b0;
      internal_reset_q <= 1'b0;
      mode_code_q      <= `PIMC_MODE_ACTIVE;
    end
    else
    begin
      channel_drive_q  <= drive_d;
      uv_detect_en_q   <= ~in_sleep;  // see RULE9
      serial_out_en_q  <= ~in_sleep;  // see RULE10
      internal_reset_q <= pin_reset;  // see RULE11
      mode_code_q      <= mode_code;
    end
  end

  // bus read path
  logic [31:0] status_word;
  always_comb
  begin
    status_word                     = 32'h00000000;
    status_word[`PIMC_ST_IN_A]      = in_a;  // see RULE4
    status_word[`PIMC_ST_IN_B]      = in_b;  // see RULE4
    status_word[`PIMC_ST_KILL]      = kill_lvl;  // see RULE16
    status_word[`PIMC_ST_RSTPIN]    = rst_pin_n;
    status_word[`PIMC_ST_MODE_LO]   = mode_code[0];
    status_word[`PIMC_ST_MODE_HI]   = mode_code[1];
  end

  wire rd_take   = s_axi_arvalid & s_axi_arready;
  wire rd_direct = s_axi_araddr == `PIMC_OFS_DIRECT;
  wire rd_map_a  = s_axi_araddr == `PIMC_OFS_MAP_A;
  wire rd_map_b  = s_axi_araddr == `PIMC_OFS_MAP_B;
  wire rd_cfg    = s_axi_araddr == `PIMC_OFS_CONFIG;
  wire rd_pmap   = s_axi_araddr == `PIMC_OFS_PGEN_MAP;
  wire rd_stat   = s_axi_araddr == `PIMC_OFS_STATUS;
  wire rd_known  = rd_direct | rd_map_a | rd_map_b | rd_cfg | rd_pmap | rd_stat;
  wire rd_ok     = rd_known & ~in_sleep;  // see RULE10

  wire [31:0] rd_word =
      ~rd_ok    ? 32'h00000000 :
      rd_direct ? {24'h000000, direct_q} :
      rd_map_a  ? {24'h000000, input_a_channel_map} :
      rd_map_b  ? {24'h000000, input_b_channel_map} :
      rd_cfg    ? {30'h00000000, reset_pin_unmask, kill_pin_unmask} :
      rd_pmap   ? {16'h0000, pgen_map_q} :
      status_word;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PIMC_RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_ok ? `PIMC_RESP_OKAY : `PIMC_RESP_SLVERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end
endmodule : pimc_top

//--- sim/pimc_chk.sv
// assertions on the ports of the mode control block
`timescale 1ns/10ps
`include "pimc_cfg.svh"
module pimc_chk #(
  parameter int LP_FILT_CYC = `PIMC_LP_FILT_CYC,
  parameter int NCH         = `PIMC_CHANNELS
) (
  // clock and reset
  input wire logic           mclk,
  input wire logic           arst_n,
  // pins
  input wire logic           parallel_cmd_input_a,
  input wire logic           parallel_cmd_input_b,
  input wire logic           lowpower_req_n,
  input wire logic           external_reset_n,
  // block outputs
  input wire logic [NCH-1:0] channel_drive_q,
  input wire logic           uv_detect_en_q,
  input wire logic           serial_out_en_q,
  input wire logic           internal_reset_q,
  input wire logic [1:0]     mode_code_q,
  // bus handshakes
  input wire logic           s_axi_awvalid,
  input wire logic           s_axi_awready,
  input wire logic           s_axi_wvalid,
  input wire logic           s_axi_wready,
  input wire logic           s_axi_bvalid,
  input wire logic           s_axi_arvalid,
  input wire logic           s_axi_arready,
  input wire logic           s_axi_rvalid,
  input wire logic [1:0]     s_axi_rresp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // one settled cycle first, the side flops may trail the mode flop
  uv_off_a: assert property (mode_code_q == `PIMC_MODE_SLEEP && $past(mode_code_q) == `PIMC_MODE_SLEEP
    |-> !uv_detect_en_q) else $error("detector on in sleep");
  so_off_a: assert property (mode_code_q == `PIMC_MODE_SLEEP && $past(mode_code_q) == `PIMC_MODE_SLEEP
    |-> !serial_out_en_q) else $error("serial out on in sleep");
  sleep_err_a: assert property (mode_code_q == `PIMC_MODE_SLEEP && s_axi_rvalid
    |-> s_axi_rresp == `PIMC_RESP_SLVERR) else $error("read accepted in sleep");
  rst_off_a: assert property (internal_reset_q && $past(internal_reset_q) |-> channel_drive_q == '0)
    else $error("channel on in reset");
  rst_cause_a: assert property ($rose(internal_reset_q) |-> !$past(external_reset_n, 2))
    else $error("reset without pin");
  fb_chan_a: assert property (mode_code_q == `PIMC_MODE_FALLBACK && $past(mode_code_q) == `PIMC_MODE_FALLBACK
    |-> channel_drive_q[NCH-1:4] == '0 && channel_drive_q[1:0] == 2'h0) else $error("fallback channel");
  // a mode change needs the request pin low well before it
  lp_filter_a: assert property (mode_code_q != `PIMC_MODE_ACTIVE && $past(mode_code_q) == `PIMC_MODE_ACTIVE
    |-> !$past(lowpower_req_n, 3) && !$past(lowpower_req_n, 4)) else $error("unfiltered mode change");
  sleep_cause_a: assert property ($changed(mode_code_q) && mode_code_q == `PIMC_MODE_SLEEP
    |-> !$past(parallel_cmd_input_a, 3) && !$past(parallel_cmd_input_b, 3)) else $error("sleep with input");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("late write response");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read data");
  cover property (mode_code_q == `PIMC_MODE_FALLBACK);
  cover property (mode_code_q == `PIMC_MODE_SLEEP);
  cover property (internal_reset_q);
endmodule : pimc_chk
bind pimc_top pimc_chk #(.LP_FILT_CYC(LP_FILT_CYC), .NCH(NCH)) chk (.mclk, .arst_n, .parallel_cmd_input_a,
  .parallel_cmd_input_b, .lowpower_req_n, .external_reset_n, .channel_drive_q, .uv_detect_en_q,
  .serial_out_en_q, .internal_reset_q, .mode_code_q, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp);

//--- sim/pimc_mcu.sv
// controller model driving the parallel, safety and low-power pins
`timescale 1ns/10ps
module pimc_mcu (
  // clock
  input  wire logic mclk,
  // pins toward the block
  output logic      parallel_cmd_input_a,
  output logic      parallel_cmd_input_b,
  output logic      lowpower_req_n,
  output logic      external_reset_n,
  output logic      output_kill_pin
);
  initial
  begin
    parallel_cmd_input_a = 1'b0;
    parallel_cmd_input_b = 1'b0;
    lowpower_req_n       = 1'b1;
    external_reset_n     = 1'b1;
    output_kill_pin      = 1'b0;
  end
  // level pins change just after an edge
  task automatic pins(input logic a, input logic b, input logic k, input logic r);
    @(posedge mclk);
    parallel_cmd_input_a <= a;
    parallel_cmd_input_b <= b;
    output_kill_pin      <= k;
    external_reset_n     <= r;
  endtask : pins
  // n below the filter time is a deliberate glitch
  task automatic idle(input logic lv, input int n);
    @(posedge mclk);
    lowpower_req_n <= lv;
    repeat (n) @(posedge mclk);
  endtask : idle
endmodule : pimc_mcu

//--- sim/tb_top.sv
// self-checking bench for the mode control block
`timescale 1ns/10ps
`include "pimc_cfg.svh"
module tb_top;
  localparam logic [1:0] OK = `PIMC_RESP_OKAY;
  localparam logic [1:0] SE = `PIMC_RESP_SLVERR;
  logic        mclk, arst_n, parallel_cmd_input_a, parallel_cmd_input_b, lowpower_req_n;
  logic        external_reset_n, output_kill_pin, uv_detect_en_q, serial_out_en_q, internal_reset_q;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  pgen_out, mode_code_q, s_axi_bresp, s_axi_rresp;
  logic [7:0]  channel_drive_q, s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          mismatches, n_tests;
  pimc_mcu mcu (.mclk, .parallel_cmd_input_a, .parallel_cmd_input_b, .lowpower_req_n, .external_reset_n,
    .output_kill_pin);
  // short filter keeps mode changes quick in simulation
  pimc_top #(.LP_FILT_CYC(4)) DUT (.mclk, .arst_n, .parallel_cmd_input_a, .parallel_cmd_input_b, .lowpower_req_n,
    .external_reset_n, .output_kill_pin, .pgen_out, .channel_drive_q, .uv_detect_en_q, .serial_out_en_q,
    .internal_reset_q, .mode_code_q, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic results;
    $display("mismatches %0d of %0d comparisons", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd
  // pins pass sync and filter stages before the output flop
  task automatic see(input logic [7:0] e);
    repeat (8) @(posedge mclk);
    chk(32'(channel_drive_q), 32'(e));
  endtask : see
  task automatic t_glitch;
    mcu.idle(1'b0, 1);
    mcu.idle(1'b1, 12);
    chk(32'(mode_code_q), 32'(`PIMC_MODE_ACTIVE));
  endtask : t_glitch
  task automatic t_default;
    mcu.pins(1'b1, 1'b0, 1'b0, 1'b1);
    see(8'h04);
    mcu.pins(1'b0, 1'b1, 1'b0, 1'b1);
    see(8'h08);
    rd(`PIMC_OFS_STATUS, 32'h0000000A, OK);
    wr(`PIMC_OFS_STATUS, 32'h0000003F, SE);
    rd(8'h18, 32'h00000000, SE);
  endtask : t_default
  task automatic t_map;
    wr(`PIMC_OFS_MAP_A, 32'h00000081, OK);
    wr(`PIMC_OFS_MAP_B, 32'h00000000, OK);
    wr(`PIMC_OFS_DIRECT, 32'h00000010, OK);
    // lane 0 strobe off: the direct bits must keep their value
    s_axi_wstrb <= 4'hE;
    wr(`PIMC_OFS_DIRECT, 32'h000000FF, OK);
    s_axi_wstrb <= 4'hF;
    wr(`PIMC_OFS_PGEN_MAP, 32'h00000020, OK);
    rd(`PIMC_OFS_MAP_A, 32'h00000081, OK);
    see(8'h10);
    pgen_out <= 2'b01;
    mcu.pins(1'b1, 1'b1, 1'b0, 1'b1);
    see(8'hB1);
    pgen_out <= 2'b10;
    see(8'h91);
  endtask : t_map
  task automatic t_kill;
    mcu.pins(1'b1, 1'b1, 1'b1, 1'b1);
    see(8'h91);
    rd(`PIMC_OFS_STATUS, 32'h0000000F, OK);
    wr(`PIMC_OFS_CONFIG, 32'h00000001, OK);
    see(8'h00);
    mcu.pins(1'b1, 1'b1, 1'b0, 1'b1);
    see(8'h91);
  endtask : t_kill
  task automatic t_rstpin;
    mcu.pins(1'b1, 1'b1, 1'b0, 1'b0);
    see(8'h91);
    chk(32'(internal_reset_q), 32'h00000000);
    mcu.pins(1'b1, 1'b1, 1'b0, 1'b1);
    wr(`PIMC_OFS_CONFIG, 32'h00000003, OK);
    mcu.pins(1'b1, 1'b1, 1'b0, 1'b0);
    see(8'h00);
    chk(32'(internal_reset_q), 32'h00000001);
    wr(`PIMC_OFS_MAP_A, 32'h00000001, SE);
    rd(`PIMC_OFS_MAP_A, 32'(`PIMC_RST_MAP_A), OK);
    mcu.pins(1'b1, 1'b1, 1'b0, 1'b1);
    see(8'h0C);
  endtask : t_rstpin
  task automatic t_fallback;
    wr(`PIMC_OFS_MAP_A, 32'h00000001, OK);
    mcu.pins(1'b1, 1'b0, 1'b0, 1'b1);
    see(8'h01);
    mcu.idle(1'b0, 12);
    see(8'h04);
    chk(32'(mode_code_q), 32'(`PIMC_MODE_FALLBACK));
    rd(`PIMC_OFS_STATUS, 32'h00000019, OK);
    wr(`PIMC_OFS_DIRECT, 32'h000000FF, SE);
  endtask : t_fallback
  task automatic t_sleep;
    mcu.pins(1'b0, 1'b0, 1'b0, 1'b1);
    see(8'h00);
    chk(32'(mode_code_q), 32'(`PIMC_MODE_SLEEP));
    chk(32'(uv_detect_en_q), 32'h00000000);
    chk(32'(serial_out_en_q), 32'h00000000);
    rd(`PIMC_OFS_MAP_A, 32'h00000000, SE);
    mcu.idle(1'b1, 12);
    chk(32'(uv_detect_en_q), 32'h00000001);
    chk(32'(serial_out_en_q), 32'h00000001);
    rd(`PIMC_OFS_MAP_A, 32'(`PIMC_RST_MAP_A), OK);
    rd(`PIMC_OFS_CONFIG, 32'h00000000, OK);
  endtask : t_sleep
  initial
  begin
    {arst_n, pgen_out, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    mismatches = 0;
    n_tests = 0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    t_glitch;
    t_default;
    t_map;
    t_kill;
    t_rstpin;
    t_fallback;
    t_sleep;
    results;
  end
  // whole run is well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    results;
  end
endmodule : tb_top
